/* lst_regs.sv */
// apb register bank: low-speed threshold, root hub descriptors and status
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lst_regs import lst_pkg::*; #(
   parameter logic [7:0]  POTPGT_RST = 8'h01,
   parameter logic        NO_OVERCURRENT_PROTECT_RST   = 1'h0,
   parameter logic        OVERCURRENT_PROTECT_MODE_RST   = 1'h1,
   parameter logic        NPS_RST    = 1'h0,
   parameter logic        PSM_RST    = 1'h1,
   parameter logic [1:0]  NDP_VAL    = 2'h2,
   parameter logic [2:0]  PPCM_RST   = 3'h0,
   parameter logic [2:0]  DR_RST     = 3'h0
) (
   // clock, reset, enable
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   pce,
   // apb slave
   input  wire logic [LST_ADDR_W-1:0]  paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [LST_DATA_W-1:0]  pwdata,
   output logic      [LST_DATA_W-1:0]  prdata,
   output logic                        pready,
   output logic                        pslverr,
   // controller state
   input  wire lst_hc_state_t          hc_state,
   // frame timing
   input  wire logic                   bit_tick,
   input  wire logic [LST_FRM_W-1:0]   frame_interval,
   output logic      [LST_FRM_W-1:0]   frame_time_left,
   // low-speed scheduling
   input  wire logic                   ls_req,
   output logic                        ls_go,
   // configuration to the root hub
   output logic      [LST_THR_W-1:0]   lowspeed_threshold_value,
   output logic      [LST_DATA_W-1:0]  root_hub_descriptor_a,
   output logic      [LST_DATA_W-1:0]  root_hub_descriptor_b,
   output logic      [LST_DATA_W-1:0]  hub_status_reg,
   output logic      [LST_DATA_W*LST_NPORTS-1:0] port_status_reg
);

   localparam logic [LST_DATA_W-1:0] DSCA_RST = {POTPGT_RST, 11'h000, NO_OVERCURRENT_PROTECT_RST, OVERCURRENT_PROTECT_MODE_RST,
                                                 1'h0, NPS_RST, PSM_RST, 8'h00};
   localparam logic [LST_DATA_W-1:0] DSCB_RST = {13'h0000, PPCM_RST, 13'h0000, DR_RST};

   logic [LST_IDX_W-1:0]  idx;
   logic                  lane_ok;
   logic                  is_oper;
   logic                  acc;
   logic                  wr_en;
   logic                  rd_setup;
   logic                  rd_map;
   logic                  wr_map;
   logic [LST_DATA_W-1:0] rd_word;
   logic [LST_DATA_W-1:0] rd_q;
   logic [LST_THR_W-1:0]  thr_q;
   logic [LST_DATA_W-1:0] dsca_q;
   logic [LST_DATA_W-1:0] dscb_q;
   logic [LST_DATA_W-1:0] hub_q;
   logic [LST_DATA_W-1:0] port_q [LST_NPORTS];
   logic                  oper_q;

   lst_frame_if frm ();

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   // true when the word index equals a register code
   function automatic logic code_hit(input logic [LST_IDX_W-1:0] i,
                                     input logic [LST_IDX_W-1:0] code);
      code_hit = (i == code);
   endfunction

   // true when the index falls on one of the port status codes
   function automatic logic port_hit(input logic [LST_IDX_W-1:0] i,
                                     input logic [LST_IDX_W-1:0] base);
      port_hit = (i >= base) && (i < base + LST_IDX_W'(LST_NPORTS));
   endfunction

   assign idx      = lst_index(paddr);
   assign lane_ok  = (paddr[1:0] == LST_LANE_OK);
   assign is_oper  = (hc_state == LST_ST_OPER);
   assign acc      = psel && penable && pce;
   assign wr_en    = acc && pwrite && lane_ok;
   assign rd_setup = psel && !penable && pce && !pwrite;

   // reads use the read codes and writes the write codes
   assign rd_map = code_hit(idx, LST_RD_THR)  || code_hit(idx, LST_RD_DSCA)
                || code_hit(idx, LST_RD_DSCB) || code_hit(idx, LST_RD_HUB)
                || port_hit(idx, LST_RD_PORT);
   assign wr_map = code_hit(idx, LST_WR_THR)  || code_hit(idx, LST_WR_DSCA)
                || code_hit(idx, LST_WR_DSCB) || code_hit(idx, LST_WR_HUB)
                || port_hit(idx, LST_WR_PORT);

   // apb handshake: one wait-free access phase, stalled while the enable is low
   assign pready  = acc;
   assign pslverr = acc && (!lane_ok || !(pwrite ? wr_map : rd_map));

   ////////////////////////////////////////////////////////////////////////////
   // read path

   // read mux, reserved bits forced to zero
   always_comb begin
      rd_word = LST_WORD_0;
      if (code_hit(idx, LST_RD_THR)) begin
         rd_word = LST_THR_MASK & LST_DATA_W'(thr_q);
      end else if (code_hit(idx, LST_RD_DSCA)) begin
         rd_word = dsca_q | LST_DATA_W'(NDP_VAL);
      end else if (code_hit(idx, LST_RD_DSCB)) begin
         rd_word = dscb_q;
      end else if (code_hit(idx, LST_RD_HUB)) begin
         rd_word = hub_q;
      end else begin
         for (int i = 0; i < LST_NPORTS; i++) begin
            if (code_hit(idx, LST_RD_PORT + LST_IDX_W'(i))) begin
               rd_word = port_q[i];
            end
         end
      end
      if (!lane_ok) begin
         rd_word = LST_WORD_0;
      end
   end

   // read data captured in the setup cycle, shown in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= LST_WORD_0;
      end else if (rd_setup) begin
         rd_q <= rd_word;
      end
   end

   assign prdata = rd_q;

   ////////////////////////////////////////////////////////////////////////////
   // threshold register

   // only a software write may change the threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_q <= LST_THR_RST;
      end else if (wr_en && code_hit(idx, LST_WR_THR)) begin
         thr_q <= pwdata[LST_THR_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // descriptor registers, writable in any state

   // descriptor A keeps only its writable fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dsca_q <= DSCA_RST;
      end else if (wr_en && code_hit(idx, LST_WR_DSCA)) begin
         dsca_q <= pwdata & LST_DSCA_WM;
      end
   end

   // descriptor B: port power mask and removable bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dscb_q <= DSCB_RST;
      end else if (wr_en && code_hit(idx, LST_WR_DSCB)) begin
         dscb_q <= pwdata & LST_DSCB_WM;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hub and port status, writable only while operational

   // hub status word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hub_q <= LST_WORD_0;
      end else if (wr_en && is_oper && code_hit(idx, LST_WR_HUB)) begin
         hub_q <= pwdata;
      end
   end

   // port status words, one per downstream port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < LST_NPORTS; i++) begin
            port_q[i] <= LST_WORD_0;
         end
      end else if (wr_en && is_oper) begin
         for (int i = 0; i < LST_NPORTS; i++) begin
            if (code_hit(idx, LST_WR_PORT + LST_IDX_W'(i))) begin
               port_q[i] <= pwdata;
            end
         end
      end
   end

   // flatten the port words onto the output bus
   always_comb begin
      port_status_reg = '0;
      for (int i = 0; i < LST_NPORTS; i++) begin
         port_status_reg[i*LST_DATA_W +: LST_DATA_W] = port_q[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame timing and low-speed gate

   // remember the state to spot entry into operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oper_q <= 1'b0;
      end else if (pce) begin
         oper_q <= is_oper;
      end
   end

   assign frm.tick     = bit_tick;
   assign frm.interval = frame_interval;
   assign frm.op_enter = is_oper && !oper_q;

   lst_frame_timer u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .pce     (pce),
      .frm     (frm.timer)
   );

   // a low-speed transaction may start only with enough frame time left
   assign ls_go = ls_req && (frm.remaining >= LST_FRM_W'(thr_q));

   assign frame_time_left          = frm.remaining;
   assign lowspeed_threshold_value = thr_q;
   assign root_hub_descriptor_a    = dsca_q | LST_DATA_W'(NDP_VAL);
   assign root_hub_descriptor_b    = dscb_q;
   assign hub_status_reg           = hub_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence wr_at(logic [LST_IDX_W-1:0] code);
      wr_en && idx == code;
   endsequence

   sequence rd_setup_at(logic [LST_IDX_W-1:0] code);
      rd_setup && lane_ok && idx == code;
   endsequence

   ls_gate_a: assert property (ls_go |-> frm.remaining >= LST_FRM_W'(thr_q))
      else $error("low-speed start granted with too little frame time");

   ls_grant_a: assert property (ls_req && frm.remaining >= LST_FRM_W'(thr_q) |-> ls_go)
      else $error("low-speed start refused with enough frame time");

   thr_hold_a: assert property (!(wr_en && code_hit(idx, LST_WR_THR))
      |=> $stable(thr_q))
      else $error("threshold changed without a write");

   thr_write_a: assert property (wr_at(LST_WR_THR)
      |=> thr_q == $past(pwdata[LST_THR_W-1:0]))
      else $error("threshold write code not honoured");

   thr_read_a: assert property (rd_setup_at(LST_RD_THR) ##1 acc
      |-> prdata == LST_DATA_W'(thr_q))
      else $error("threshold read returned wrong word");

   dsca_any_a: assert property (wr_en && code_hit(idx, LST_WR_DSCA) && !is_oper
      |=> dsca_q == ($past(pwdata) & LST_DSCA_WM))
      else $error("descriptor A write lost outside operation");

   dscb_any_a: assert property (wr_at(LST_WR_DSCB)
      |=> dscb_q == ($past(pwdata) & LST_DSCB_WM))
      else $error("descriptor B write code not honoured");

   hub_lock_a: assert property (wr_en && code_hit(idx, LST_WR_HUB) && !is_oper
      |=> $stable(hub_q))
      else $error("hub status written outside operation");

   hub_write_a: assert property (wr_en && code_hit(idx, LST_WR_HUB) && is_oper
      |=> hub_q == $past(pwdata))
      else $error("hub status word not stored whole");

   // no write of any kind may touch the port words outside operation
   port_lock_a: assert property (wr_en && !is_oper |=> $stable(port_status_reg))
      else $error("port status written outside operation");

   rsvd_zero_a: assert property (rd_setup_at(LST_RD_DSCA)
      |=> (prdata & ~LST_DSCA_RM) == LST_WORD_0)
      else $error("descriptor A reserved bits read nonzero");

   fixed_fld_a: assert property (root_hub_descriptor_a[1:0] == NDP_VAL
      && !root_hub_descriptor_a[10])
      else $error("descriptor A fixed fields altered");

endmodule
`default_nettype wire

/* lst_pkg.sv */
// shared constants and types for the low-speed threshold and root hub register bank
package lst_pkg;

   // bus geometry
   localparam int unsigned LST_ADDR_W   = 10;
   localparam int unsigned LST_DATA_W   = 32;
   localparam int unsigned LST_IDX_W    = 8;
   localparam int unsigned LST_THR_W    = 11;
   localparam int unsigned LST_FRM_W    = 14;
   localparam int unsigned LST_NPORTS   = 2;
   localparam logic [1:0]  LST_LANE_OK  = 2'h0;

   // register codes: read code, write code has bit 7 set
   localparam logic [7:0]  LST_RD_THR   = 8'h11;
   localparam logic [7:0]  LST_WR_THR   = 8'h91;
   localparam logic [7:0]  LST_RD_DSCA  = 8'h12;
   localparam logic [7:0]  LST_WR_DSCA  = 8'h92;
   localparam logic [7:0]  LST_RD_DSCB  = 8'h13;
   localparam logic [7:0]  LST_WR_DSCB  = 8'h93;
   localparam logic [7:0]  LST_RD_HUB   = 8'h14;
   localparam logic [7:0]  LST_WR_HUB   = 8'h94;
   localparam logic [7:0]  LST_RD_PORT  = 8'h15;
   localparam logic [7:0]  LST_WR_PORT  = 8'h95;

   // reset values and writable field masks
   localparam logic [10:0] LST_THR_RST  = 11'h628;
   localparam logic [31:0] LST_THR_MASK = 32'h0000_07ff;
   localparam logic [31:0] LST_DSCA_WM  = 32'hff00_1b00;
   localparam logic [31:0] LST_DSCB_WM  = 32'h0007_0007;
   localparam logic [31:0] LST_DSCA_RM  = 32'hff00_1b03;
   localparam logic [31:0] LST_WORD_0   = 32'h0000_0000;
   localparam logic [13:0] LST_FRM_0    = 14'h0000;
   localparam logic [13:0] LST_FRM_1    = 14'h0001;

   // host controller operating states, as driven by the state logic
   typedef enum logic [1:0] {
      LST_ST_RESET  = 2'h0,
      LST_ST_RESUME = 2'h1,
      LST_ST_OPER   = 2'h2,
      LST_ST_SUSP   = 2'h3
   } lst_hc_state_t;

   // word index of a byte address
   function automatic logic [LST_IDX_W-1:0] lst_index(input logic [LST_ADDR_W-1:0] a);
      lst_index = a[LST_ADDR_W-1:2];
   endfunction

endpackage

/* lst_frame_if.sv */
// carrier between the register bank and the frame countdown
`timescale 1ns/1ps
`default_nettype none
interface lst_frame_if;
   import lst_pkg::*;
   logic                 tick;
   logic                 op_enter;
   logic [LST_FRM_W-1:0] interval;
   logic [LST_FRM_W-1:0] remaining;

   modport timer (input tick, input op_enter, input interval, output remaining);
   modport ctrl  (output tick, output op_enter, output interval, input remaining);
endinterface
`default_nettype wire

/* lst_frame_timer.sv */
// frame time countdown, one step per bit time
`timescale 1ns/1ps
`default_nettype none
module lst_frame_timer import lst_pkg::*; (
   // clock and reset
   input  wire logic    pclk,
   input  wire logic    presetn,
   input  wire logic    pce,
   // link to the register bank
   lst_frame_if.timer   frm
);

   logic [LST_FRM_W-1:0] rem_q;

   // count down per bit time, reload at zero or on entering operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem_q <= LST_FRM_0;
      end else if (pce) begin
         if (frm.op_enter) begin
            rem_q <= frm.interval;
         end else if (frm.tick) begin
            if (rem_q == LST_FRM_0) begin
               rem_q <= frm.interval;
            end else begin
               rem_q <= rem_q - LST_FRM_1;
            end
         end
      end
   end

   assign frm.remaining = rem_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   count_down_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && frm.tick && !frm.op_enter && rem_q != LST_FRM_0
      |=> rem_q == $past(rem_q) - LST_FRM_1)
      else $error("frame countdown did not step by one");

   count_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      pce && frm.tick && rem_q == LST_FRM_0 |=> rem_q == $past(frm.interval))
      else $error("frame countdown did not reload at zero");

   count_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(pce && (frm.tick || frm.op_enter)) |=> $stable(rem_q))
      else $error("frame countdown moved without a bit time");

endmodule
`default_nettype wire

/* lst_regs_note_end.sv */
// intentionally empty companion file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* lst_apb_host.sv */
// apb host model standing in for the controller driver on the register bus
`timescale 1ns/1ps
`default_nettype none
module lst_apb_host import lst_pkg::*; (
   // clock
   input  wire logic                  pclk,
   // apb master side
   output logic     [LST_ADDR_W-1:0]  paddr,
   output logic                       psel,
   output logic                       penable,
   output logic                       pwrite,
   output logic     [LST_DATA_W-1:0]  pwdata,
   input  wire logic [LST_DATA_W-1:0] prdata,
   input  wire logic                  pready,
   input  wire logic                  pslverr
);
   // idle bus from time zero
   initial begin
      paddr   = '0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      pwdata  = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one whole-word transfer; the request stands until pready is seen high
   task automatic xfer(input logic [LST_ADDR_W-1:0] a, input logic w,
                       input logic [LST_DATA_W-1:0] d, output logic [LST_DATA_W-1:0] rd,
                       output logic er);
      @(posedge pclk);
      psel    <= 1'b1; // whole 32-bit word, code in address
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0; // configuration written during access phase only
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the threshold and root hub register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top import lst_pkg::*; ;
   // clock, reset and stimulus
   logic                          pclk, presetn, pce, bit_tick, ls_req, ls_go;
   logic [LST_ADDR_W-1:0]         paddr;
   logic                          psel, penable, pwrite, pready, pslverr;
   logic [LST_DATA_W-1:0]         pwdata, prdata, dsca, dscb, hub;
   logic [2*LST_DATA_W-1:0]       ports;
   logic [LST_THR_W-1:0]          thr;
   logic [LST_FRM_W-1:0]          frame_interval, frame_time_left;
   lst_hc_state_t                 hc_state;
   int                            failures, n_tests, m;
   logic [31:0]                   shadow [int];
   logic [31:0]                   d, r;
   logic                          e;
   logic [9:0]                    bad_a [5] = '{10'h244, 10'h044, 10'h045, 10'h080, 10'h3fc};
   logic                          bad_w [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

   lst_apb_host host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   lst_regs DUT (.pclk(pclk), .presetn(presetn), .pce(pce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hc_state(hc_state), .bit_tick(bit_tick),
      .frame_interval(frame_interval), .frame_time_left(frame_time_left), .ls_req(ls_req),
      .ls_go(ls_go), .lowspeed_threshold_value(thr), .root_hub_descriptor_a(dsca),
      .root_hub_descriptor_b(dscb), .hub_status_reg(hub), .port_status_reg(ports));

   // 250 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // verdict in one place
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // register access by code, byte address is four times the code
   task automatic wr(input logic [7:0] c, input logic [31:0] v);
      host.xfer({c, 2'b00}, 1'b1, v, r, e);
      `CHK(e, 1'b0)
   endtask

   // read a register, check for no error and compare with the shadow copy
   task automatic rd(input logic [7:0] c);
      host.xfer({c, 2'b00}, 1'b0, 32'h0, r, e);
      `CHK(e, 1'b0)
      `CHK(r, shadow[c])
   endtask

   task automatic check_all();
      for (int c = 8'h11; c <= 8'h16; c++)
         rd(c[7:0]);
      #1;
      `CHK(thr, shadow[8'h11][10:0])
      `CHK(dsca, shadow[8'h12])
      `CHK(dscb, shadow[8'h13])
      `CHK(hub, shadow[8'h14])
      `CHK(ports, {shadow[8'h16], shadow[8'h15]})
   endtask

   // watchdog far beyond the expected few hundred cycles
   initial begin
      #100000;
      failures++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      presetn = 1'b0;
      pce = 1'b1;
      hc_state = LST_ST_RESET;
      bit_tick = 1'b0;
      ls_req = 1'b0;
      frame_interval = 14'h0014;
      failures = 0;
      n_tests = 0;
      void'($urandom(73));
      shadow[8'h11] = 32'h0000_0628;
      shadow[8'h12] = 32'h0100_0902;
      for (int c = 8'h13; c <= 8'h16; c++)
         shadow[c] = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      check_all(); // reset values
      $display("test reset_values done");

      // threshold write with reserved bits set
      d = $urandom;
      wr(LST_WR_THR[7:0], d | 32'hfff0_0000);
      shadow[8'h11] = d & LST_THR_MASK; // reserved bits ignored
      check_all();
      $display("test threshold_rw done");

      // descriptor writes in every state, status writes only when operational
      for (int s = 0; s < 4; s++) begin
         @(posedge pclk);
         hc_state <= lst_hc_state_t'(s);
         d = $urandom;
         wr(LST_WR_DSCA, d);
         shadow[8'h12] = (d & LST_DSCA_WM) | 32'h0000_0002;
         d = $urandom;
         wr(LST_WR_DSCB, d);
         shadow[8'h13] = d & LST_DSCB_WM;
         for (int c = 8'h94; c <= 8'h96; c++) begin
            d = $urandom;
            wr(c[7:0], d);
            if (s == 2)
               shadow[c - 8'h80] = d;
         end
         check_all();
      end
      $display("test state_write_rules done");

      // refused accesses: wrong direction, misaligned, unmapped
      for (int i = 0; i < 5; i++) begin
         host.xfer(bad_a[i], bad_w[i], 32'hffff_ffff, r, e);
         `CHK(e, 1'b1)
         if (!bad_w[i])
            `CHK(r, 32'h0)
      end
      check_all();
      $display("test refused_access done");

      // low-speed gate against the frame countdown
      wr(LST_WR_THR, 32'h0000_0005);
      shadow[8'h11] = 32'h5;
      @(posedge pclk);
      hc_state <= LST_ST_RESET;
      @(posedge pclk);
      hc_state <= LST_ST_OPER;
      repeat (3) @(posedge pclk);
      #1;
      m = 20;
      `CHK(frame_time_left, m[13:0])
      @(posedge pclk);
      bit_tick <= 1'b1;
      for (int i = 0; i < 45; i++) begin
         @(posedge pclk);
         ls_req <= 1'($urandom);
         #1;
         m = (m == 0) ? 20 : m - 1;
         `CHK(frame_time_left, m[13:0])
         `CHK(ls_go, ls_req && (m >= 5))
      end
      // clock enable low freezes the countdown although ticks go on
      @(posedge pclk);
      pce <= 1'b0;
      m = (m == 0) ? 20 : m - 1;
      repeat (3) @(posedge pclk);
      #1;
      `CHK(frame_time_left, m[13:0])
      @(posedge pclk);
      pce <= 1'b1;
      bit_tick <= 1'b0;
      check_all(); // threshold untouched by frame activity
      $display("test lowspeed_gate done");
      wrap_up();
   end
endmodule
`default_nettype wire
